// file: rtl/ufbt_defines.svh
// Register offsets, field positions and reset values of the serial port
`ifndef UFBT_DEFINES_SVH
`define UFBT_DEFINES_SVH
`define UFBT_OFS_DATA_LOW 8'h00
`define UFBT_OFS_DATA_HIGH 8'h04
`define UFBT_OFS_STATUS 8'h08
`define UFBT_OFS_FEATURE 8'h0C
`define UFBT_OFS_ENABLE 8'h10
`define UFBT_OFS_FRAME 8'h14
`define UFBT_OFS_BAUD 8'h18
`define UFBT_ST_RX_DONE 7
`define UFBT_ST_TX_DONE 6
`define UFBT_ST_TX_EMPTY 5
`define UFBT_FC_RX_IE 7
`define UFBT_FC_TX_DONE_IE 6
`define UFBT_FC_TX_EMPTY_IE 5
`define UFBT_FC_LOOPBACK 3
`define UFBT_EC_RX_EN 7
`define UFBT_EC_TX_EN 6
`define UFBT_EC_OPEN_DRAIN 3
`define UFBT_EC_DOUBLE 2
`define UFBT_RH_OVERRUN 6
`define UFBT_RH_FRAMING 2
`define UFBT_RH_PARITY 1
`define UFBT_BAUD_RST 16'h0040
`define UFBT_BAUD_MIN 17'h00040
`define UFBT_FRAC_STEP 17'h00040
`define UFBT_S_NORMAL 5'h10
`define UFBT_S_DOUBLE 5'h08
`define UFBT_S_SYNC 5'h02
`define UFBT_S_CLIENT 5'h01
`endif

// file: rtl/ufbt_pkg.sv
// Types shared by the serial port design
package ufbt_pkg;
    // Transmit and receive sequencers, Gray along start-data-parity-stop
    typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
        TX_PAR = 3'h2, TX_STOP = 3'h6} ufbt_tx_state_e;
    typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
        RX_PAR = 3'h2, RX_STOP = 3'h6} ufbt_rx_state_e;
    // Communication mode field
    typedef enum logic [1:0] {MODE_ASYNC = 2'h0, MODE_SYNC_HOST = 2'h1,
        MODE_SYNC_CLIENT = 2'h2, MODE_RSVD = 2'h3} ufbt_mode_e;
    // Character width field
    typedef enum logic [2:0] {CW_5 = 3'h0, CW_6 = 3'h1, CW_7 = 3'h2, CW_8 = 3'h3,
        CW_R4 = 3'h4, CW_R5 = 3'h5, CW_9L = 3'h6, CW_9H = 3'h7} ufbt_char_width_e;
endpackage : ufbt_pkg

// file: rtl/ufbt_top.sv
// Serial port framing, fractional baud generator, transmitter and basic receiver
// Function
// - Frame: start, 5-9 data, parity, 1-2 stops
// - Parity bit sits between data and stop
// - Line idles high; frames may follow back-to-back
// - Odd or even parity generated and checked
// - Baud divisor is factor times 64
// - Synchronous mode uses integer divisor field only
// - Bit rate 64*clk/(S*divisor), S 16/8/2
// - Fractional generator clocks, except external clock modes
// - Data register to buffer to shifter
// - Transmit done when everything has shifted out
// - Data registers written only while empty flag set
// - Unused upper bits ignored below eight bits
// - Two-level buffers on transmit and receive
// - Line driver enable output during transmission
// - Loopback routes transmit pin to receiver
// - Open drain drives transmit pin only while low
// - Separate transmit done, empty, receive interrupts
// - Receiver detects framing, overrun, filters noise in asynchronous mode
// - Receiver completes on first stop bit
// - Error flags stored with their frame
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "ufbt_defines.svh"
module ufbt_top
    import ufbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_in,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    input wire logic sync_clock_in,
    output logic sync_clock_out,
    output logic sync_clock_oe,
    output logic line_driver_enable_out,
    output logic irq_tx_done,
    output logic irq_tx_empty,
    output logic irq_rx_done
);
    // Data bits per character
    function automatic logic [3:0] data_bits(input logic [2:0] cw);
        if (cw[2]) begin
            data_bits = 4'h9;
        end else begin
            data_bits = 4'h5 + {2'h0, cw[1:0]};
        end
    endfunction : data_bits
    // Keeps only the bits of the character width
    function automatic logic [8:0] width_mask(input logic [2:0] cw);
        width_mask = 9'h1FF >> (4'h9 - data_bits(cw));
    endfunction : width_mask
    // Two-of-three vote for noise rejection
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    logic [15:0] baud_r; // Divisor, factor times 64
    logic [7:0] feat_r; // Feature control
    logic [7:0] enab_r; // Enable control
    logic [7:0] frame_r; // Frame control
    logic tx_done_r; // Sticky transmit done flag
    logic [31:0] prdata_r; // Read data captured in setup
    logic [2:0] cw;
    ufbt_mode_e mode;
    logic par_en, par_odd, stop2, tx_en, rx_en, od_en, lb_en;
    assign cw = frame_r[2:0];
    assign mode = ufbt_mode_e'(frame_r[7:6]);
    assign par_en = frame_r[5];
    assign par_odd = frame_r[4];
    assign stop2 = frame_r[3];
    assign tx_en = enab_r[`UFBT_EC_TX_EN];
    assign rx_en = enab_r[`UFBT_EC_RX_EN];
    assign od_en = enab_r[`UFBT_EC_OPEN_DRAIN];
    assign lb_en = feat_r[`UFBT_FC_LOOPBACK];

    // Bus decode; zero wait states
    logic acc, wr_acc, rd_acc, hit;
    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign hit = (paddr <= `UFBT_OFS_BAUD) && (paddr[1:0] == 2'h0);
    assign pready = acc;
    assign pslverr = acc & ~hit;
    assign prdata = prdata_r;

    // Pin synchronisers; first stage feeds only the second
    logic rxd_s1, rxd_s2, txi_s1, txi_s2, sck_s1, sck_s2, sck_s3;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {rxd_s1, rxd_s2, txi_s1, txi_s2} <= 4'hF;
            {sck_s1, sck_s2, sck_s3} <= 3'h0;
        end else begin
            {rxd_s1, rxd_s2} <= {rxd_in, rxd_s1};
            {txi_s1, txi_s2} <= {txd_in, txi_s1};
            {sck_s1, sck_s2, sck_s3} <= {sync_clock_in, sck_s1, sck_s2};
        end
    end

    // Fractional generator: adds 64 per clock, ticks on each divisor crossed
    logic [16:0] acc_r, eff_div, acc_sum;
    logic gen_tick_r, tick;
    logic [4:0] sps;
    always_comb begin
        eff_div = {1'b0, baud_r};
        if (mode == MODE_SYNC_HOST) begin
            eff_div = {1'b0, baud_r[15:6], 6'h00};
        end
        // Guards against illegal small divisors stalling the line
        if (eff_div < `UFBT_BAUD_MIN) begin
            eff_div = `UFBT_BAUD_MIN;
        end
        acc_sum = acc_r + `UFBT_FRAC_STEP;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r <= 17'h00000;
            gen_tick_r <= 1'b0;
        end else if (acc_sum >= eff_div) begin
            acc_r <= acc_sum - eff_div;
            gen_tick_r <= 1'b1;
        end else begin
            acc_r <= acc_sum;
            gen_tick_r <= 1'b0;
        end
    end
    // Client mode steps on the external clock's rising edge
    assign tick = (mode == MODE_SYNC_CLIENT) ? (sck_s2 & ~sck_s3) : gen_tick_r;
    always_comb begin
        case (mode)
            MODE_SYNC_HOST: sps = `UFBT_S_SYNC;
            MODE_SYNC_CLIENT: sps = `UFBT_S_CLIENT;
            default: sps = enab_r[`UFBT_EC_DOUBLE] ? `UFBT_S_DOUBLE : `UFBT_S_NORMAL;
        endcase
    end

    // Transmit data register and buffer, the two write levels
    logic [8:0] dr_r, buf_r;
    logic dr_full_r, buf_full_r, load, stop_end;
    ufbt_tx_state_e tst_r;
    logic wr_low, wr_high, dr_done;
    assign wr_low = wr_acc && paddr == `UFBT_OFS_DATA_LOW && !dr_full_r;
    assign wr_high = wr_acc && paddr == `UFBT_OFS_DATA_HIGH && !dr_full_r;
    // Nine-bit low-first completes on the high byte, all others on the low
    assign dr_done = (cw == CW_9L) ? wr_high : wr_low;
    assign load = buf_full_r && tx_en && (tst_r == TX_IDLE || stop_end);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dr_r <= 9'h000;
            buf_r <= 9'h000;
            dr_full_r <= 1'b0;
            buf_full_r <= 1'b0;
        end else begin
            if (wr_low) begin
                dr_r[7:0] <= pwdata[7:0];
            end
            if (wr_high) begin
                dr_r[8] <= pwdata[0];
            end
            // Move on only when the buffer is free
            if (dr_full_r && !buf_full_r) begin
                buf_r <= dr_r & width_mask(cw);
                buf_full_r <= 1'b1;
                dr_full_r <= 1'b0;
            end else if (dr_done) begin
                dr_full_r <= 1'b1;
            end
            if (load) begin
                buf_full_r <= 1'b0;
            end
        end
    end

    // Transmit sequencer
    logic [8:0] tsh_r;
    logic [4:0] tcnt_r;
    logic [3:0] tbit_r;
    logic tpar_r, bit_end, line_bit;
    assign bit_end = tick && (tcnt_r == sps - 5'h01);
    assign stop_end = (tst_r == TX_STOP) && bit_end && !(stop2 && tbit_r == 4'h0);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tst_r <= TX_IDLE;
            tsh_r <= 9'h000;
            tcnt_r <= 5'h00;
            tbit_r <= 4'h0;
            tpar_r <= 1'b0;
        end else if (load) begin
            // Back-to-back frames start straight from the stop bit
            tst_r <= TX_START;
            tsh_r <= buf_r;
            tpar_r <= (^buf_r) ^ par_odd;
            tcnt_r <= 5'h00;
            tbit_r <= 4'h0;
        end else if (tst_r != TX_IDLE && tick) begin
            tcnt_r <= bit_end ? 5'h00 : tcnt_r + 5'h01;
            if (bit_end) begin
                case (tst_r)
                    TX_START: begin
                        tst_r <= TX_DATA;
                    end
                    TX_DATA: begin
                        tsh_r <= tsh_r >> 1;
                        tbit_r <= tbit_r + 4'h1;
                        if (tbit_r == data_bits(cw) - 4'h1) begin
                            tst_r <= par_en ? TX_PAR : TX_STOP;
                            tbit_r <= 4'h0;
                        end
                    end
                    TX_PAR: begin
                        tst_r <= TX_STOP;
                    end
                    TX_STOP: begin
                        // Second stop only when asked for
                        if (stop2 && tbit_r == 4'h0) begin
                            tbit_r <= 4'h1;
                        end else begin
                            tst_r <= TX_IDLE;
                        end
                    end
                    default: begin
                        tst_r <= TX_IDLE;
                    end
                endcase
            end
        end
    end
    always_comb begin
        case (tst_r)
            TX_START: line_bit = 1'b0;
            TX_DATA: line_bit = tsh_r[0];
            TX_PAR: line_bit = tpar_r;
            default: line_bit = 1'b1;
        endcase
    end

    // Pin drive, registered; open drain only pulls low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            line_driver_enable_out <= 1'b0;
            sync_clock_out <= 1'b0;
            sync_clock_oe <= 1'b0;
        end else begin
            txd_out <= od_en ? 1'b0 : line_bit;
            txd_oe <= tx_en & (od_en ? ~line_bit : 1'b1);
            line_driver_enable_out <= (tst_r != TX_IDLE);
            // Host clock rises at the start of each bit
            sync_clock_out <= (mode == MODE_SYNC_HOST) && tst_r != TX_IDLE && tcnt_r == 5'h00;
            sync_clock_oe <= (mode == MODE_SYNC_HOST);
        end
    end

    // Transmit done flag; a new completion beats a clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_done_r <= 1'b0;
        end else if (stop_end && !buf_full_r && !dr_full_r) begin
            tx_done_r <= 1'b1;
        end else if (wr_acc && paddr == `UFBT_OFS_STATUS && pwdata[`UFBT_ST_TX_DONE]) begin
            tx_done_r <= 1'b0;
        end
    end

    // Receiver: loopback takes the transmit pin as its line
    logic rline, rprev_r, rbit, decide, big;
    logic [4:0] rcnt_r, half;
    logic [1:0] vote_r;
    logic [3:0] rbit_n_r;
    logic [8:0] rsh_r;
    logic rpar_r, rperr_r;
    ufbt_rx_state_e rst_r;
    logic push, pop;
    logic [11:0] rxq [2]; // Entry: overrun, framing, parity, nine data bits
    logic [1:0] rcount_r;
    assign rline = lb_en ? txi_s2 : rxd_s2;
    assign half = sps >> 1;
    assign big = sps >= `UFBT_S_DOUBLE;
    // Majority of three mid-bit samples when oversampling allows
    assign decide = tick && rcnt_r == (big ? half + 5'h01 : half);
    assign rbit = big ? maj3(vote_r[1], vote_r[0], rline) : rline;
    assign push = decide && rst_r == RX_STOP;
    assign pop = rd_acc && rcount_r != 2'h0 &&
        paddr == ((cw == CW_9L) ? `UFBT_OFS_DATA_HIGH : `UFBT_OFS_DATA_LOW);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_r <= RX_IDLE;
            rprev_r <= 1'b1;
            rcnt_r <= 5'h00;
            vote_r <= 2'h3;
            rbit_n_r <= 4'h0;
            rsh_r <= 9'h000;
            rpar_r <= 1'b0;
            rperr_r <= 1'b0;
        end else begin
            rprev_r <= rline;
            if (!rx_en) begin
                rst_r <= RX_IDLE;
            end else if (rst_r == RX_IDLE) begin
                if (rprev_r && !rline) begin
                    rst_r <= RX_START;
                    rcnt_r <= 5'h00;
                    rbit_n_r <= 4'h0;
                    rsh_r <= 9'h000;
                    rpar_r <= par_odd;
                end
            end else if (tick) begin
                rcnt_r <= (rcnt_r == sps - 5'h01) ? 5'h00 : rcnt_r + 5'h01;
                vote_r <= {vote_r[0], rline};
                if (decide) begin
                    rcnt_r <= 5'h00 - (sps - rcnt_r - 5'h01);
                    case (rst_r)
                        RX_START: begin
                            rst_r <= rbit ? RX_IDLE : RX_DATA;
                        end
                        RX_DATA: begin
                            rsh_r[rbit_n_r] <= rbit;
                            rpar_r <= rpar_r ^ rbit;
                            rbit_n_r <= rbit_n_r + 4'h1;
                            if (rbit_n_r == data_bits(cw) - 4'h1) begin
                                rst_r <= par_en ? RX_PAR : RX_STOP;
                            end
                        end
                        RX_PAR: begin
                            rperr_r <= rpar_r ^ rbit;
                            rst_r <= RX_STOP;
                        end
                        default: begin
                            rst_r <= RX_IDLE;
                        end
                    endcase
                end
                if (decide && rst_r == RX_DATA && rbit_n_r == 4'h0) begin
                    rperr_r <= 1'b0;
                end
            end
        end
    end

    // Two-entry receive buffer, oldest at index 0
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rcount_r <= 2'h0;
            rxq[0] <= 12'h000;
            rxq[1] <= 12'h000;
        end else if (!rx_en) begin
            rcount_r <= 2'h0; // Disabling flushes at once
        end else begin
            if (pop) begin
                rxq[0] <= rxq[1];
            end
            if (push && rcount_r == 2'h2 && !pop) begin
                rxq[1][11] <= 1'b1;
            end else if (push) begin
                // Slot after any same-cycle pop, so the surviving entry is kept
                rxq[(rcount_r == 2'h2 || (!pop && rcount_r == 2'h1)) ? 1 : 0] <=
                    {1'b0, ~rbit, par_en & rperr_r, rsh_r};
            end
            if (push && !pop && rcount_r != 2'h2) begin
                rcount_r <= rcount_r + 2'h1;
            end else if (pop && !push) begin
                rcount_r <= rcount_r - 2'h1;
            end
        end
    end

    // Register writes; data and status handled above
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            baud_r <= `UFBT_BAUD_RST;
            feat_r <= 8'h00;
            enab_r <= 8'h00;
            frame_r <= 8'h03;
        end else if (wr_acc) begin
            case (paddr)
                `UFBT_OFS_FEATURE: feat_r <= pwdata[7:0];
                `UFBT_OFS_ENABLE: enab_r <= pwdata[7:0];
                `UFBT_OFS_FRAME: frame_r <= pwdata[7:0];
                `UFBT_OFS_BAUD: baud_r <= pwdata[15:0];
                default: baud_r <= baud_r;
            endcase
        end
    end

    // Read data captured in the setup cycle; unmapped reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                `UFBT_OFS_DATA_LOW: prdata_r <= {24'h000000, rxq[0][7:0]};
                `UFBT_OFS_DATA_HIGH: prdata_r <= {24'h000000, rcount_r != 2'h0,
                    rxq[0][11], 3'h0, rxq[0][10], rxq[0][9], rxq[0][8]};
                `UFBT_OFS_STATUS: prdata_r <= {24'h000000, rcount_r != 2'h0,
                    tx_done_r, !dr_full_r, 5'h00};
                `UFBT_OFS_FEATURE: prdata_r <= {24'h000000, feat_r};
                `UFBT_OFS_ENABLE: prdata_r <= {24'h000000, enab_r};
                `UFBT_OFS_FRAME: prdata_r <= {24'h000000, frame_r};
                `UFBT_OFS_BAUD: prdata_r <= {16'h0000, baud_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    // Three separate interrupt lines
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_tx_done <= 1'b0;
            irq_tx_empty <= 1'b0;
            irq_rx_done <= 1'b0;
        end else begin
            irq_tx_done <= tx_done_r & feat_r[`UFBT_FC_TX_DONE_IE];
            irq_tx_empty <= !dr_full_r & feat_r[`UFBT_FC_TX_EMPTY_IE];
            irq_rx_done <= (rcount_r != 2'h0) & feat_r[`UFBT_FC_RX_IE];
        end
    end

    // Checks
    sequence s_last_data;
        tst_r == TX_DATA && bit_end && tbit_r == data_bits(cw) - 4'h1;
    endsequence
    property p_idle_high;
        @(posedge ref_clk) disable iff (rst) tst_r == TX_IDLE && !od_en |=> txd_out;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not high");
    property p_start_low;
        @(posedge ref_clk) disable iff (rst) tst_r == TX_START && tx_en && !od_en |=>
            !txd_out && txd_oe;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start not low");
    property p_par_pos;
        @(posedge ref_clk) disable iff (rst) s_last_data ##0 par_en |=> tst_r == TX_PAR;
    endproperty
    a_par_pos: assert property (p_par_pos) else $error("parity misplaced");
    property p_move;
        @(posedge ref_clk) disable iff (rst) dr_full_r && !buf_full_r |=> !dr_full_r ##0 buf_full_r;
    endproperty
    a_move: assert property (p_move) else $error("data not moved");
    property p_done;
        @(posedge ref_clk) disable iff (rst) $rose(tx_done_r) |-> $past(stop_end) && !buf_full_r;
    endproperty
    a_done: assert property (p_done) else $error("done too early");
    property p_drv;
        @(posedge ref_clk) disable iff (rst) tst_r == TX_START |=> line_driver_enable_out;
    endproperty
    a_drv: assert property (p_drv) else $error("driver enable low");
    property p_full_wr;
        @(posedge ref_clk) disable iff (rst) wr_acc && dr_full_r |=>
            dr_r == $past(dr_r);
    endproperty
    a_full_wr: assert property (p_full_wr) else $error("write accepted when full");
    property p_ovf;
        @(posedge ref_clk) disable iff (rst) push && !pop && rcount_r == 2'h2 && rx_en |=>
            rxq[1][11] && rcount_r == 2'h2;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overrun lost");
    property p_tick;
        @(posedge ref_clk) disable iff (rst) gen_tick_r && eff_div >= 17'h00080 |=> !gen_tick_r;
    endproperty
    a_tick: assert property (p_tick) else $error("baud ticks too fast");
endmodule : ufbt_top

// file: bench/ufbt_remote_model.sv
// Remote serial device: captures frames off the line and sends frames back
`timescale 1ns/1ps
module ufbt_remote_model (
    input wire logic ref_clk,
    input wire logic line_in,
    input wire logic drv_en,
    input wire logic [3:0] nbits,
    input wire logic par_en,
    input wire logic [4:0] bit_len,
    output logic line_out,
    output logic drv_seen
);
    logic [10:0] got_q[$]; // Captured frames as stop, parity, data
    logic [10:0] frm; // Frame under capture
    // Line rests high until a frame is sent
    initial line_out = 1'b1;
    // Capture at bit centres, counted from the falling start edge
    always begin
        @(negedge line_in);
        frm = 11'h000;
        repeat (bit_len / 2) @(posedge ref_clk);
        drv_seen = drv_en;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_len) @(posedge ref_clk);
            frm[i] = line_in;
        end
        if (par_en) begin
            repeat (bit_len) @(posedge ref_clk);
            frm[9] = line_in;
        end
        repeat (bit_len) @(posedge ref_clk);
        frm[10] = line_in;
        got_q.push_back(frm);
    end
    // Send one 8-bit frame; a low stop level makes a framing fault
    task automatic send_frame(input logic [7:0] d, input logic stop_lvl);
        @(posedge ref_clk);
        line_out <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (bit_len) @(posedge ref_clk);
            line_out <= d[i];
        end
        repeat (bit_len) @(posedge ref_clk);
        line_out <= stop_lvl;
        repeat (bit_len) @(posedge ref_clk);
        line_out <= 1'b1;
        repeat (bit_len) @(posedge ref_clk);
    endtask : send_frame
endmodule : ufbt_remote_model

// file: bench/usart_frame_baud_transmit_tb_top.sv
// Self-checking bench for the serial port framing, baud and transmit path
`timescale 1ns/1ps
`include "ufbt_defines.svh"
module usart_frame_baud_transmit_tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rxd_in, txd_out, txd_oe, drv_seen, de, slv, irq_d, irq_e, irq_rx;
    logic [3:0] nbits = 4'h8; // Character width seen by the remote side
    logic par_en = 1'b0;
    logic [4:0] bit_len = 5'h10; // Cycles per bit at divisor 64
    int mismatches = 0, samples_checked = 0, cycles = 0;
    ufbt_top ufbt_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_in(rxd_in), .txd_in(txd_out), .txd_out(txd_out),
        .txd_oe(txd_oe), .sync_clock_in(1'b0), .sync_clock_out(), .sync_clock_oe(),
        .line_driver_enable_out(de), .irq_tx_done(irq_d), .irq_tx_empty(irq_e),
        .irq_rx_done(irq_rx));
    ufbt_remote_model ufbt_remote_model_inst (.ref_clk(ref_clk), .line_in(txd_out),
        .drv_en(de), .nbits(nbits), .par_en(par_en), .bit_len(bit_len), .line_out(rxd_in),
        .drv_seen(drv_seen));
    always #5 ref_clk = ~ref_clk;
    // Cut a hang short; the whole run needs far fewer cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Data writes only once the empty flag shows room
    task automatic tx_write(input logic [7:0] a, input logic [7:0] d);
        do apb(1'b0, `UFBT_OFS_STATUS, 32'h0); while (rd[`UFBT_ST_TX_EMPTY] !== 1'b1);
        apb(1'b1, a, {24'h0, d});
    endtask : tx_write
    // Wait for a captured frame, compare, let the stop bit finish
    task automatic expect_frame(input logic [10:0] exp);
        while (ufbt_remote_model_inst.got_q.size() == 0) @(posedge ref_clk);
        check("frame", {21'h0, exp}, {21'h0, ufbt_remote_model_inst.got_q.pop_front()});
        repeat (20) @(posedge ref_clk);
    endtask : expect_frame
    task automatic final_report();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        check("idle line", 32'h1, {31'h0, txd_out});
        apb(1'b0, `UFBT_OFS_BAUD, 32'h0);
        check("baud reset", 32'h40, rd);
        apb(1'b0, `UFBT_OFS_STATUS, 32'h0);
        check("status reset", 32'h20, rd);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped", 32'h1, {31'h0, slv});
        apb(1'b1, `UFBT_OFS_BAUD, 32'h40);
        apb(1'b1, `UFBT_OFS_FRAME, 32'h03);
        apb(1'b1, `UFBT_OFS_ENABLE, 32'hC0);
        tx_write(`UFBT_OFS_DATA_LOW, 8'h55);
        expect_frame(11'h455);
        check("driver enable", 32'h3, {30'h0, drv_seen, txd_oe});
        apb(1'b0, `UFBT_OFS_STATUS, 32'h0);
        check("tx done", 32'h60, rd);
        apb(1'b1, `UFBT_OFS_STATUS, 32'h40);
        apb(1'b0, `UFBT_OFS_STATUS, 32'h0);
        check("done cleared", 32'h20, rd);
        $display("Test single frame done");
        tx_write(`UFBT_OFS_DATA_LOW, 8'hA3);
        tx_write(`UFBT_OFS_DATA_LOW, 8'h3C);
        tx_write(`UFBT_OFS_DATA_LOW, 8'h99);
        expect_frame(11'h4A3);
        expect_frame(11'h43C);
        expect_frame(11'h499);
        par_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `UFBT_OFS_FRAME, k ? 32'h33 : 32'h23);
            tx_write(`UFBT_OFS_DATA_LOW, 8'h07);
            expect_frame(k ? 11'h407 : 11'h607);
        end
        par_en <= 1'b0;
        nbits <= 4'h5;
        apb(1'b1, `UFBT_OFS_FRAME, 32'h00);
        tx_write(`UFBT_OFS_DATA_LOW, 8'hFF);
        expect_frame(11'h41F);
        nbits <= 4'h9;
        apb(1'b1, `UFBT_OFS_FRAME, 32'h06);
        tx_write(`UFBT_OFS_DATA_LOW, 8'h5A);
        tx_write(`UFBT_OFS_DATA_HIGH, 8'h01);
        expect_frame(11'h55A);
        nbits <= 4'h8;
        bit_len <= 5'h08;
        apb(1'b1, `UFBT_OFS_FRAME, 32'h03);
        apb(1'b1, `UFBT_OFS_ENABLE, 32'hC4);
        tx_write(`UFBT_OFS_DATA_LOW, 8'h3C);
        expect_frame(11'h43C);
        // Host mode: integer divisor 2, two samples, four cycles a bit
        bit_len <= 5'h04;
        apb(1'b1, `UFBT_OFS_BAUD, 32'h80);
        apb(1'b1, `UFBT_OFS_FRAME, 32'h43);
        tx_write(`UFBT_OFS_DATA_LOW, 8'hC6);
        expect_frame(11'h4C6);
        bit_len <= 5'h10;
        apb(1'b1, `UFBT_OFS_BAUD, 32'h40);
        apb(1'b1, `UFBT_OFS_FRAME, 32'h03);
        apb(1'b1, `UFBT_OFS_ENABLE, 32'hC0);
        $display("Test transmit formats done");
        apb(1'b1, `UFBT_OFS_FEATURE, 32'hE8);
        tx_write(`UFBT_OFS_DATA_LOW, 8'h96);
        expect_frame(11'h496);
        check("irqs", 32'h7, {29'h0, irq_d, irq_e, irq_rx});
        apb(1'b0, `UFBT_OFS_DATA_LOW, 32'h0);
        check("loopback", 32'h96, rd);
        apb(1'b1, `UFBT_OFS_FEATURE, 32'h00);
        ufbt_remote_model_inst.send_frame(8'hA5, 1'b1);
        apb(1'b0, `UFBT_OFS_DATA_HIGH, 32'h0);
        check("rx status", 32'h80, rd);
        apb(1'b0, `UFBT_OFS_DATA_LOW, 32'h0);
        check("rx data", 32'hA5, rd);
        ufbt_remote_model_inst.send_frame(8'h0F, 1'b0);
        apb(1'b0, `UFBT_OFS_DATA_HIGH, 32'h0);
        check("rx framing", 32'h84, rd);
        ufbt_remote_model_inst.send_frame(8'h11, 1'b1);
        ufbt_remote_model_inst.send_frame(8'h22, 1'b1);
        apb(1'b0, `UFBT_OFS_DATA_LOW, 32'h0);
        apb(1'b0, `UFBT_OFS_DATA_HIGH, 32'h0);
        check("rx overrun", 32'hC0, rd);
        $display("Test receive done");
        final_report();
    end
endmodule : usart_frame_baud_transmit_tb_top
